//--- verilog/sata_defines.vh
// Constants shared by the shift, add and tagged-add execution unit.
`ifndef SATA_DEFINES_VH
`define SATA_DEFINES_VH

// Operation codes of the six-bit operation code field.
`define SATA_OP_ADD 6'h00
`define SATA_OP_ADDCC 6'h10
`define SATA_OP_ADDX 6'h08
`define SATA_OP_ADDXCC 6'h18
`define SATA_OP_TADD 6'h20
`define SATA_OP_TADDTV 6'h22
`define SATA_OP_SUB 6'h04
`define SATA_OP_SUBCC 6'h14
`define SATA_OP_SUBX 6'h0C
`define SATA_OP_SUBXCC 6'h1C
`define SATA_OP_SLL 6'h25
`define SATA_OP_SRL 6'h26
`define SATA_OP_SRA 6'h27

// Shifter kinds.
`define SATA_SH_LEFT 2'h0
`define SATA_SH_RIGHT 2'h1
`define SATA_SH_ARITH 2'h2

// Register byte offsets on the bus.
`define SATA_ADR_ICC 8'h00
`define SATA_ADR_INT_STATUS 8'h04
`define SATA_ADR_INT_CLEAR 8'h08
`define SATA_ADR_INT_ENABLE 8'h0C
`define SATA_ADR_LAST_RESULT 8'h10
`define SATA_ADR_OP_COUNT 8'h14

// Condition code bit positions.
`define SATA_ICC_N 3
`define SATA_ICC_Z 2
`define SATA_ICC_V 1
`define SATA_ICC_C 0

// Event bit positions of status, clear and enable.
`define SATA_EV_TAG_TRAP 0
`define SATA_EV_SHIFT_RSVD 1
`define SATA_EV_BAD_OP 2
`define SATA_EV_WIDTH 3

// Reset values.
`define SATA_ICC_RESET 4'h0
`define SATA_EV_RESET 3'h0

// Field positions of the signed immediate.
`define SATA_IMM_SIGN 12
`define SATA_SHCNT_MSB 4
`define SATA_RSVD_LSB 5

`endif

//--- verilog/sata_shifter.v
// Five-stage barrel shifter for logical and arithmetic shifts.
`timescale 1ns/1ps
`include "sata_defines.vh"

module sata_shifter (
  input wire [31:0] value_i,
  input wire [4:0] amount_i,
  input wire [1:0] kind_i,
  output wire [31:0] result_o
);

  wire [31:0] stage [0:5];
  wire fill;

  assign fill = (kind_i == `SATA_SH_ARITH) ? value_i[31] : 1'b0; // RULE_04
  assign stage[0] = value_i;

  genvar k;
  generate
    for (k = 0; k < 5; k = k + 1) begin : g_stage
      wire [31:0] moved;
      // A zero amount bit passes the stage through, so a zero count leaves the value intact.
      if (k == 4) begin : g_wide
        assign moved = (kind_i == `SATA_SH_LEFT) ?
          {stage[k][15:0], 16'h0000} : // RULE_03
          {{16{fill}}, stage[k][31:16]}; // RULE_04
      end else begin : g_narrow
        assign moved = (kind_i == `SATA_SH_LEFT) ?
          {stage[k][31-(1<<k):0], {(1<<k){1'b0}}} : // RULE_03
          {{(1<<k){fill}}, stage[k][31:(1<<k)]}; // RULE_04
      end
      assign stage[k+1] = amount_i[k] ? moved : stage[k]; // RULE_05
    end
  endgenerate

  assign result_o = stage[5];

endmodule // sata_shifter

//--- verilog/sata_alu.v
// Integer execution unit: shifts, adds, subtracts and tagged adds with a Wishbone register port.
// How it works
// RULE_01: Register-form shift count is low five bits of second source; immediate uses count field.
// RULE_02: Immediate shifts expect zeros in instruction bits 5 to 12 from the supplier.
// RULE_03: Left logical shift moves first source left, zero-filling low bits.
// RULE_04: Right shifts fill upper bits with zeros, or with the sign bit if arithmetic.
// RULE_05: A zero shift count passes the first source through unchanged.
// RULE_06: Shifts write the destination and never touch the condition codes.
// RULE_07: Add and flag-setting add write first source plus second operand.
// RULE_08: Carry forms of add also add the current status carry bit.
// RULE_09: Flag-setting adds update codes; overflow when like-signed operands give unlike sum.
// RULE_10: Tag overflow when either operand has bit 1 or 0 set, or add overflows.
// RULE_11: Trapping tagged add on tag overflow traps, keeping destination and codes.
// RULE_12: Trapping tagged add without overflow writes sum and codes with overflow zero.
// RULE_13: Plain tagged add sets overflow from tag overflow, updates codes, writes sum.
// RULE_14: The four subtract opcodes are decoded.
// RULE_15: Subtracts compute first minus second, minus carry for carry forms.
// RULE_16: Subtract overflow when signs differ and difference sign differs from first source.
// RULE_17: Forms without the flag suffix leave condition codes unchanged.
// RULE_18: Carry is bit-31 carry out; negative and zero follow the 32-bit result.
`timescale 1ns/1ps
`include "sata_defines.vh"

module sata_alu (
  input wire clk_i,
  input wire nrst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire exec_valid_i,
  input wire [5:0] operation_code_field_i,
  input wire imm_select_i,
  input wire [31:0] first_source_register_i,
  input wire [31:0] second_source_register_i,
  input wire [12:0] signed_immediate_13_i,
  input wire [4:0] dest_index_i,
  output reg result_valid_o,
  output reg [31:0] result_o,
  output reg [4:0] dest_index_o,
  output reg dest_write_o,
  output reg icc_write_o,
  output wire [3:0] icc_o,
  output reg tag_overflow_trap_o,
  output wire irq_o
);

  // Reset is released through two flops so every register leaves reset on the same edge.
  reg rst_meta;
  reg rst_sync;
  wire rst_n;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign rst_n = rst_sync;

  // Opcode class helpers, used only by the adder set-up; the result decode cases on the opcode itself.
  function is_sub;
    input [5:0] op;
    begin
      is_sub = (op == `SATA_OP_SUB) || (op == `SATA_OP_SUBCC) ||
        (op == `SATA_OP_SUBX) || (op == `SATA_OP_SUBXCC); // RULE_14
    end
  endfunction

  function uses_carry;
    input [5:0] op;
    begin
      uses_carry = (op == `SATA_OP_ADDX) || (op == `SATA_OP_ADDXCC) ||
        (op == `SATA_OP_SUBX) || (op == `SATA_OP_SUBXCC);
    end
  endfunction

  // Condition codes: negative, zero, overflow, carry.
  reg [3:0] icc;
  reg [2:0] int_status;
  reg [2:0] int_enable;
  reg [31:0] last_result;
  reg [31:0] op_count;

  assign icc_o = icc;

  // Second operand and shift amount.
  wire [31:0] imm_ext;
  wire [31:0] op2;
  wire [4:0] shift_amount;
  wire shift_rsvd_bad;

  assign imm_ext = {{19{signed_immediate_13_i[`SATA_IMM_SIGN]}}, signed_immediate_13_i};
  assign op2 = imm_select_i ? imm_ext : second_source_register_i; // RULE_07
  assign shift_amount = imm_select_i ?
    signed_immediate_13_i[`SATA_SHCNT_MSB:0] : second_source_register_i[4:0]; // RULE_01
  // Nonzero reserved bits are only noted; the count still comes from the low five bits.
  assign shift_rsvd_bad = imm_select_i &&
    (signed_immediate_13_i[`SATA_IMM_SIGN:`SATA_RSVD_LSB] != 8'h00); // RULE_02

  // One adder serves add and subtract: subtract adds the inverted operand.
  wire op_sub;
  wire op_carry;
  wire [31:0] b_eff;
  wire carry_in;
  wire [32:0] sum33;
  wire [31:0] sum;

  assign op_sub = is_sub(operation_code_field_i);
  assign op_carry = uses_carry(operation_code_field_i);
  assign b_eff = op_sub ? ~op2 : op2; // RULE_15
  assign carry_in = op_sub ? (op_carry ? ~icc[`SATA_ICC_C] : 1'b1) : // RULE_15
    (op_carry & icc[`SATA_ICC_C]); // RULE_08
  assign sum33 = {1'b0, first_source_register_i} + {1'b0, b_eff} + {32'h00000000, carry_in};
  assign sum = sum33[31:0];

  wire add_ovf;
  wire sub_ovf;
  wire add_carry;
  wire sub_borrow;
  wire tag_ovf;

  assign add_ovf = (first_source_register_i[31] == op2[31]) &&
    (sum[31] != first_source_register_i[31]); // RULE_09
  assign sub_ovf = (first_source_register_i[31] != op2[31]) &&
    (sum[31] != first_source_register_i[31]); // RULE_16
  assign add_carry = sum33[32]; // RULE_18
  assign sub_borrow = ~sum33[32];
  assign tag_ovf = (first_source_register_i[1:0] != 2'h0) || (op2[1:0] != 2'h0) ||
    add_ovf; // RULE_10

  // Shifter.
  reg [1:0] shift_kind;
  wire [31:0] shift_result;

  always @* begin
    case (operation_code_field_i)
      `SATA_OP_SRL: shift_kind = `SATA_SH_RIGHT;
      `SATA_OP_SRA: shift_kind = `SATA_SH_ARITH;
      default: shift_kind = `SATA_SH_LEFT;
    endcase
  end

  sata_shifter u_shifter (
    .value_i(first_source_register_i),
    .amount_i(shift_amount),
    .kind_i(shift_kind),
    .result_o(shift_result)
  );

  // Result decode.
  reg [31:0] next_result;
  reg next_write;
  reg next_icc_write;
  reg [3:0] next_icc;
  reg next_trap;
  reg next_bad_op;
  reg next_rsvd;

  always @* begin
    next_result = sum;
    next_write = 1'b0;
    next_icc_write = 1'b0;
    next_icc = icc;
    next_trap = 1'b0;
    next_bad_op = 1'b0;
    next_rsvd = 1'b0;
    case (operation_code_field_i)
      `SATA_OP_SLL, `SATA_OP_SRL, `SATA_OP_SRA: begin
        next_result = shift_result;
        next_write = 1'b1; // RULE_06
        next_rsvd = shift_rsvd_bad;
      end
      `SATA_OP_ADD, `SATA_OP_ADDX: begin
        next_write = 1'b1; // RULE_17
      end
      `SATA_OP_ADDCC, `SATA_OP_ADDXCC: begin
        next_write = 1'b1; // RULE_07
        next_icc_write = 1'b1; // RULE_09
        next_icc = {sum[31], sum == 32'h00000000, add_ovf, add_carry}; // RULE_18
      end
      `SATA_OP_SUB, `SATA_OP_SUBX: begin
        next_write = 1'b1; // RULE_17
      end
      `SATA_OP_SUBCC, `SATA_OP_SUBXCC: begin
        next_write = 1'b1;
        next_icc_write = 1'b1; // RULE_15
        next_icc = {sum[31], sum == 32'h00000000, sub_ovf, sub_borrow}; // RULE_16
      end
      `SATA_OP_TADD: begin
        next_write = 1'b1;
        next_icc_write = 1'b1;
        next_icc = {sum[31], sum == 32'h00000000, tag_ovf, add_carry}; // RULE_13
      end
      `SATA_OP_TADDTV: begin
        if (tag_ovf) begin
          next_trap = 1'b1; // RULE_11
        end else begin
          next_write = 1'b1;
          next_icc_write = 1'b1;
          next_icc = {sum[31], sum == 32'h00000000, 1'b0, add_carry}; // RULE_12
        end
      end
      default: begin
        next_bad_op = 1'b1;
      end
    endcase
  end

  // Bus decode.
  wire bus_req;
  wire bus_write;
  wire [2:0] ev_set;
  wire [2:0] ev_clear;

  assign bus_req = wb_cyc_i && wb_stb_i;
  // A write lands on the edge at which the master sees ack high.
  assign bus_write = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign ev_clear = (bus_write && (wb_adr_i == `SATA_ADR_INT_CLEAR)) ?
    wb_dat_i[`SATA_EV_WIDTH-1:0] : `SATA_EV_RESET;
  assign ev_set = exec_valid_i ? {next_bad_op, next_rsvd, next_trap} : `SATA_EV_RESET;

  // Execution stage and condition codes.
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      result_valid_o <= 1'b0;
      result_o <= 32'h00000000;
      dest_index_o <= 5'h00;
      dest_write_o <= 1'b0;
      icc_write_o <= 1'b0;
      tag_overflow_trap_o <= 1'b0;
      icc <= `SATA_ICC_RESET;
      last_result <= 32'h00000000;
      op_count <= 32'h00000000;
    end else begin
      result_valid_o <= exec_valid_i;
      dest_write_o <= exec_valid_i && next_write; // RULE_11
      icc_write_o <= exec_valid_i && next_icc_write; // RULE_06
      tag_overflow_trap_o <= exec_valid_i && next_trap; // RULE_11
      if (exec_valid_i) begin
        result_o <= next_result;
        dest_index_o <= dest_index_i;
        op_count <= op_count + 32'h00000001;
        if (next_write) begin
          last_result <= next_result;
        end
      end
      // An instruction that sets the codes wins over a software write in the same cycle.
      if (exec_valid_i && next_icc_write) begin
        icc <= next_icc; // RULE_17
      end else if (bus_write && (wb_adr_i == `SATA_ADR_ICC)) begin
        icc <= wb_dat_i[3:0];
      end
    end
  end

  // Interrupt status: a new event beats a clear in the same cycle.
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      int_status <= `SATA_EV_RESET;
      int_enable <= `SATA_EV_RESET;
    end else begin
      int_status <= (int_status & ~ev_clear) | ev_set;
      if (bus_write && (wb_adr_i == `SATA_ADR_INT_ENABLE)) begin
        int_enable <= wb_dat_i[`SATA_EV_WIDTH-1:0];
      end
    end
  end

  assign irq_o = |(int_status & int_enable);

  // Wishbone answer: ack one cycle after the request, dropped the cycle after.
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      if (bus_req && !wb_ack_o) begin
        case (wb_adr_i)
          `SATA_ADR_ICC: wb_dat_o <= {28'h0000000, icc};
          `SATA_ADR_INT_STATUS: wb_dat_o <= {29'h00000000, int_status};
          `SATA_ADR_INT_ENABLE: wb_dat_o <= {29'h00000000, int_enable};
          `SATA_ADR_LAST_RESULT: wb_dat_o <= last_result;
          `SATA_ADR_OP_COUNT: wb_dat_o <= op_count;
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // sata_alu

//--- sim/sata_alu_properties.sv
// Concurrent checks on the execution and bus ports of the unit.
`timescale 1ns/1ps
`include "sata_defines.vh"
module sata_alu_properties (
  input wire clk_i,
  input wire nrst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire exec_valid_i,
  input wire [5:0] operation_code_field_i,
  input wire imm_select_i,
  input wire [31:0] first_source_register_i,
  input wire [31:0] second_source_register_i,
  input wire [12:0] signed_immediate_13_i,
  input wire result_valid_o,
  input wire [31:0] result_o,
  input wire dest_write_o,
  input wire icc_write_o,
  input wire [3:0] icc_o,
  input wire tag_overflow_trap_o
);
  wire [5:0] op = operation_code_field_i;
  wire [31:0] a = first_source_register_i;
  wire [31:0] b = imm_select_i ? {{19{signed_immediate_13_i[12]}}, signed_immediate_13_i}
                               : second_source_register_i;
  wire [31:0] sum = a + b;
  wire tag_ov = (|a[1:0]) | (|b[1:0]) | (a[31] == b[31] && sum[31] != a[31]);
  wire [31:0] sll_val = a << second_source_register_i[4:0];
  wire go_sh = exec_valid_i && op[5:2] == 4'h9 && op[1:0] != 2'h0;
  wire go_plain = exec_valid_i && (op == `SATA_OP_ADD || op == `SATA_OP_ADDX ||
                                   op == `SATA_OP_SUB || op == `SATA_OP_SUBX);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  issue_answer_a: assert property (exec_valid_i |=> result_valid_o)
    else $error("No result one cycle after issue.");
  shift_keeps_icc_a: assert property (go_sh |=> !icc_write_o && $stable(icc_o))
    else $error("Shift touched the condition codes.");
  shift_count_a: assert property (go_sh && op == `SATA_OP_SLL && !imm_select_i
    |=> dest_write_o && result_o == $past(sll_val)) else $error("Left shift value wrong.");
  plain_keeps_icc_a: assert property (go_plain |=> !icc_write_o && dest_write_o)
    else $error("Plain form changed the condition codes.");
  add_sum_a: assert property (exec_valid_i && op == `SATA_OP_ADD
    |=> result_o == $past(sum)) else $error("Add result wrong.");
  trap_holds_a: assert property (exec_valid_i && op == `SATA_OP_TADDTV && tag_ov
    |=> tag_overflow_trap_o && !dest_write_o && $stable(icc_o)) else $error("Trap path wrong.");
  notrap_clears_a: assert property (exec_valid_i && op == `SATA_OP_TADDTV && !tag_ov
    |=> !tag_overflow_trap_o && dest_write_o && icc_write_o && !icc_o[`SATA_ICC_V])
    else $error("Untrapped tagged add wrong.");
  tag_flag_a: assert property (exec_valid_i && op == `SATA_OP_TADD
    |=> icc_write_o && icc_o[`SATA_ICC_V] == $past(tag_ov)) else $error("Tag flag wrong.");
  ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus answer is not a single pulse.");
  cover property (go_sh);
  cover property (tag_overflow_trap_o);
  cover property (wb_ack_o);
endmodule // sata_alu_properties

bind sata_alu sata_alu_properties i_chk (.clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .exec_valid_i, .operation_code_field_i, .imm_select_i, .first_source_register_i,
  .second_source_register_i, .signed_immediate_13_i, .result_valid_o, .result_o,
  .dest_write_o, .icc_write_o, .icc_o, .tag_overflow_trap_o);

//--- sim/sata_decode_model.sv
// Instruction decode model that feeds the execution port.
`timescale 1ns/1ps
module sata_decode_model (
  input wire logic clk_i,
  output logic exec_valid_o,
  output logic [5:0] op_o,
  output logic imm_o,
  output logic [31:0] a_o,
  output logic [31:0] b_o,
  output logic [12:0] s13_o,
  output logic [4:0] rd_o
);
  initial {exec_valid_o, op_o, imm_o, a_o, b_o, s13_o, rd_o} = '0;
  task automatic issue(input logic [5:0] op, input bit imm, input logic [31:0] a, b);
    @(posedge clk_i);
    exec_valid_o <= 1'b1;
    op_o <= op;
    imm_o <= imm;
    a_o <= a;
    b_o <= b;
    // A real decoder never sends junk above the count of an immediate shift.
    s13_o <= (imm && op[5:2] == 4'h9) ? {8'h00, b[4:0]} : b[12:0];
    rd_o <= rd_o + 5'h01;
    @(posedge clk_i);
    exec_valid_o <= 1'b0;
    #1;
  endtask
endmodule // sata_decode_model

//--- sim/shift_add_tagged_alu_bench.sv
// Self-checking bench for the shift, add and tagged-add unit.
`timescale 1ns/1ps
`include "sata_defines.vh"
module shift_add_tagged_alu_bench;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, first_source_register_i, second_source_register_i;
  logic [31:0] result_o, q;
  logic wb_ack_o, exec_valid_i, imm_select_i, result_valid_o, dest_write_o, icc_write_o;
  logic tag_overflow_trap_o, irq_o;
  logic [5:0] operation_code_field_i;
  logic [12:0] signed_immediate_13_i;
  logic [4:0] dest_index_i, dest_index_o;
  logic [3:0] icc_o;
  int n_mismatch = 0, n_tests = 0;
  sata_alu i_dut (.clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .exec_valid_i, .operation_code_field_i, .imm_select_i,
    .first_source_register_i, .second_source_register_i, .signed_immediate_13_i,
    .dest_index_i, .result_valid_o, .result_o, .dest_index_o, .dest_write_o, .icc_write_o,
    .icc_o, .tag_overflow_trap_o, .irq_o);
  sata_decode_model i_dec (.clk_i, .exec_valid_o(exec_valid_i), .op_o(operation_code_field_i),
    .imm_o(imm_select_i), .a_o(first_source_register_i), .b_o(second_source_register_i),
    .s13_o(signed_immediate_13_i), .rd_o(dest_index_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic stop_test();
    $display("Mismatches %0d in %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // The wait has no count of its own; the watchdog ends a hung bus.
  task automatic wb(input bit w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, ad, 4'hF, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    #1;
  endtask
  task automatic run(input logic [5:0] op, input bit i, input logic [31:0] a, b, r,
                     input bit w, input logic [3:0] c);
    i_dec.issue(op, i, a, b);
    chk("valid", 32'h1, {31'h0, result_valid_o});
    chk("result", r, result_o);
    chk("dest_index", {27'h0, i_dec.rd_o}, {27'h0, dest_index_o});
    chk("dest_write", {31'h0, w}, {31'h0, dest_write_o});
    chk("trap", {31'h0, op == `SATA_OP_TADDTV && !w}, {31'h0, tag_overflow_trap_o});
    chk("icc_write", {31'h0, (op[5:4] == 2'h1) || (op == `SATA_OP_TADD) ||
      (op == `SATA_OP_TADDTV && w)}, {31'h0, icc_write_o});
    chk("icc", {28'h0, c}, {28'h0, icc_o});
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    run(`SATA_OP_ADDCC, 0, 32'h1, 32'h2, 32'h3, 1, 4'h0);
    run(`SATA_OP_ADDCC, 0, 32'h7FFFFFFF, 32'h1, 32'h80000000, 1, 4'hA);
    run(`SATA_OP_ADDCC, 0, 32'hFFFFFFFF, 32'h1, 32'h0, 1, 4'h5);
    run(`SATA_OP_ADDX, 0, 32'h5, 32'h1, 32'h7, 1, 4'h5);
    run(`SATA_OP_ADDXCC, 1, 32'hA, 32'h1FFF, 32'hA, 1, 4'h1);
    run(`SATA_OP_ADD, 1, 32'h10, 32'h1000, 32'hFFFFF010, 1, 4'h1);
    run(`SATA_OP_SUB, 0, 32'h9, 32'h4, 32'h5, 1, 4'h1);
    run(`SATA_OP_SUBCC, 0, 32'h80000000, 32'h1, 32'h7FFFFFFF, 1, 4'h2);
    run(`SATA_OP_SUBCC, 0, 32'h3, 32'h5, 32'hFFFFFFFE, 1, 4'h9);
    run(`SATA_OP_SUBX, 0, 32'hA, 32'h3, 32'h6, 1, 4'h9);
    run(`SATA_OP_SUBXCC, 0, 32'h5, 32'h5, 32'hFFFFFFFF, 1, 4'h9);
    run(`SATA_OP_SLL, 0, 32'h80000001, 32'hFFFFFFE1, 32'h2, 1, 4'h9);
    run(`SATA_OP_SRL, 1, 32'h80000000, 32'h1FE4, 32'h08000000, 1, 4'h9);
    run(`SATA_OP_SRA, 0, 32'h80000000, 32'h4, 32'hF8000000, 1, 4'h9);
    run(`SATA_OP_SRA, 0, 32'h80000000, 32'h20, 32'h80000000, 1, 4'h9);
    run(`SATA_OP_TADD, 0, 32'h1, 32'h2, 32'h3, 1, 4'h2);
    run(`SATA_OP_TADDTV, 0, 32'h7FFFFFFC, 32'h4, 32'h80000000, 0, 4'h2);
    run(`SATA_OP_TADDTV, 0, 32'h8, 32'h4, 32'hC, 1, 4'h0);
    run(6'h01, 0, 32'h1, 32'h2, 32'h3, 0, 4'h0);
    wb(1, `SATA_ADR_INT_ENABLE, 32'h7);
    wb(0, `SATA_ADR_INT_STATUS, 32'h0);
    chk("status", 32'h5, q);
    chk("irq", 32'h1, {31'h0, irq_o});
    wb(1, `SATA_ADR_INT_CLEAR, 32'h1);
    wb(0, `SATA_ADR_INT_STATUS, 32'h0);
    chk("status", 32'h4, q);
    wb(1, `SATA_ADR_INT_ENABLE, 32'h3);
    chk("irq", 32'h0, {31'h0, irq_o});
    wb(0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(1, `SATA_ADR_ICC, 32'h1);
    run(`SATA_OP_ADDX, 0, 32'h1, 32'h1, 32'h3, 1, 4'h1);
    stop_test();
  end
  initial begin
    #50000;
    n_mismatch++;
    stop_test();
  end
endmodule // shift_add_tagged_alu_bench
